// File: rtl/door_drive_friction_energy_limit.v
// friction learning, force sums, oscillation protection and
// kinetic energy speed limits for a door drive
// assumes a wishbone classic master on core_clk and position (mm),
// current (mA) and learn-run flags synchronous to core_clk
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "door_fric_defs.vh"

////////////////////////////////////////////////////////////////////////
module door_drive_friction_energy_limit #(
    parameter PRESS_CYC = `PRESS_MS * `CLK_KHZ,     // press-on time
    parameter HOLDOFF_CYC = `HOLDOFF_MS * `CLK_KHZ  // lockout time
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire learn_run,
    input wire learn_done,
    input wire move_open,
    input wire move_close,
    input wire second_open_move,
    input wire speed_trig,
    input wire weight_done,
    input wire [15:0] eow_pos,
    input wire [15:0] pos_mm,
    input wire [15:0] cur_ma,
    input wire [15:0] learned_mass,
    input wire cmd_open,
    input wire cmd_close,
    input wire at_open_end,
    input wire at_close_end,
    output reg [15:0] eff_open_force,
    output reg [15:0] eff_close_force,
    output reg [15:0] eff_extra_a,
    output reg [15:0] eff_extra_b,
    output reg [1:0] drive_ret,
    output reg [15:0] return_force,
    output reg [15:0] torque_cmd,
    output reg osc_locked
);

    localparam E_IDLE = 2'd0;
    localparam E_LOAD = 2'd1;
    localparam E_RUN = 2'd2;
    localparam E_STORE = 2'd3;
    localparam OS_IDLE = 3'd0;
    localparam OS_HOLD = 3'd1;
    localparam OS_RET = 3'd2;
    localparam OS_PRESS = 3'd3;
    localparam OS_LOCK = 3'd4;

    // reset value of a configuration slot
    function [15:0] rst_val(input [3:0] i);
        begin
            case (i)
                4'd1, 4'd2, 4'd3, 4'd4: rst_val = `FORCE_DEF;
                4'd8, 4'd9, 4'd10: rst_val = `ENERGY_DEF;
                4'd11, 4'd12, 4'd13: rst_val = `SPEED_DEF;
                4'd14: rst_val = `CUTTER_DEF;
                4'd15: rst_val = `MOTOR_K_DEF;
                default: rst_val = 16'h0000;
            endcase
        end
    endfunction

    // written value after the force and energy ceilings
    function [15:0] wr_val(input [3:0] i, input [15:0] v, input rev);
        reg [15:0] lim;
        begin
            lim = 16'hFFFF;
            if (i >= 4'd1 && i <= 4'd4)
                lim = rev ? `FORCE_MAX_REV : `FORCE_MAX_NOREV;
            else if (i >= 4'd8 && i <= 4'd10)
                lim = rev ? `ENERGY_MAX_REV : `ENERGY_MAX_NOREV;
            wr_val = (v > lim) ? lim : v;
        end
    endfunction

    // saturate a wide result to 16 bits
    function [15:0] sat16(input [39:0] v);
        begin
            sat16 = (v[39:16] != 24'h0) ? 16'hFFFF : v[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register file and wishbone slave

    reg [15:0] cfg_q [0:15];        // writable configuration slots
    reg [39:0] sum_q [0:1];         // current sums, 0 open, 1 close
    reg [39:0] sq_q [0:1];          // sums of squared current
    reg [15:0] n_q [0:1];           // sample counts
    reg [15:0] mean_q [0:1];        // mean friction current
    reg [15:0] std_q [0:1];         // deviation of friction current
    reg [15:0] fric_q [0:1];        // friction force in N
    reg [1:0] eng_q;                // math engine state
    reg [3:0] step_q;               // math job step
    reg [39:0] q_q;                 // quotient or root
    reg [2:0] os_q;                 // oscillation state
    reg [2:0] reps_q;               // return attempts
    integer i;
    integer j;

    wire bus_req = wb_cyc_i & wb_stb_i;
    wire [3:0] idx = wb_adr_i[5:2];
    wire in_cfg = (wb_adr_i[7:6] == 2'b00);
    // writes land at the edge where the master sees ack
    wire wr_cfg = bus_req & wb_we_i & wb_ack_o & in_cfg;
    wire [15:0] wr_merge = {wb_sel_i[1] ? wb_dat_i[15:8] : cfg_q[idx][15:8],
                            wb_sel_i[0] ? wb_dat_i[7:0] : cfg_q[idx][7:0]};
    wire rev_en = cfg_q[0][`CTRL_REV_BIT];
    // speed job: which energy and which speed slot
    wire [3:0] e_idx = 4'd8 + {2'b00, step_q[2:1]};
    wire [3:0] v_idx = (step_q[2:1] == 2'd0) ? 4'd12 :
                       (step_q[2:1] == 2'd1) ? 4'd11 : 4'd13;
    wire spd_wr = (eng_q == E_STORE) & step_q[3] & step_q[0] &
                  (cfg_q[e_idx] != 16'h0000) &
                  (learned_mass != 16'h0000);
    wire spd_ev = wr_cfg & (idx >= 4'd8) & (idx <= 4'd13);

    // ack one cycle after the request, dropped the cycle after
    always @(posedge core_clk) begin
        if (sys_rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req & ~wb_ack_o;
    end

    // read data registered together with ack
    always @(posedge core_clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= 32'h0000_0000;  // unmapped reads as zero
            if (in_cfg)
                wb_dat_o <= {16'h0000, cfg_q[idx]};
            else if (wb_adr_i == `OFS_FRIC_OPEN)
                wb_dat_o <= {std_q[0], mean_q[0]};
            else if (wb_adr_i == `OFS_FRIC_CLOSE)
                wb_dat_o <= {std_q[1], mean_q[1]};
            else if (wb_adr_i == `OFS_FRIC_FORCE)
                wb_dat_o <= {fric_q[1], fric_q[0]};
            else if (wb_adr_i == `OFS_STATUS)
                wb_dat_o <= {16'h0000, n_q[0][7:0], reps_q, os_q,
                             1'b0, eng_q != E_IDLE};
        end
    end

    // configuration slots; engine speed results override the bus
    always @(posedge core_clk) begin
        if (sys_rst) begin
            for (i = 0; i < 16; i = i + 1)
                cfg_q[i] <= rst_val(i[3:0]);
        end else begin
            if (wr_cfg)
                cfg_q[idx] <= wr_val(idx, wr_merge, rev_en);
            if (spd_wr)
                cfg_q[v_idx] <= sat16(q_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // friction sampling during the learn run

    reg run_q;          // learn run seen last cycle
    reg armed_q;        // a window is open and nxt_q is valid
    reg [15:0] nxt_q;   // position of the next sample
    wire act_open = learn_run & move_open & speed_trig &
        ((second_open_move & (pos_mm <= `RANGE1_MM)) |
         (weight_done & (pos_mm > eow_pos)));
    wire act_close = learn_run & move_close & speed_trig &
        (pos_mm > cfg_q[14]);
    wire hit = move_open ? (pos_mm >= nxt_q) : (pos_mm <= nxt_q);
    wire d_s = move_close;

    // a fresh window skips the transient 2 cm before sampling
    always @(posedge core_clk) begin
        if (sys_rst) begin
            run_q <= 1'b0;
            armed_q <= 1'b0;
            nxt_q <= 16'h0000;
        end else begin
            run_q <= learn_run;
            if (!(act_open | act_close)) begin
                armed_q <= 1'b0;
            end else if (!armed_q) begin
                armed_q <= 1'b1;
                nxt_q <= move_open ? pos_mm + `STEP_MM
                                   : pos_mm - `STEP_MM;
            end else if (hit) begin
                nxt_q <= move_open ? nxt_q + `STEP_MM
                                   : nxt_q - `STEP_MM;
            end
        end
    end

    // accumulators, cleared at the start of every learn run
    always @(posedge core_clk) begin
        if (sys_rst || (learn_run & ~run_q)) begin
            for (j = 0; j < 2; j = j + 1) begin
                sum_q[j] <= 40'h00_0000_0000;
                sq_q[j] <= 40'h00_0000_0000;
                n_q[j] <= 16'h0000;
            end
        end else if ((act_open | act_close) & armed_q & hit) begin
            sum_q[d_s] <= sum_q[d_s] + {24'h00_0000, cur_ma};
            sq_q[d_s] <= sq_q[d_s] + {24'h00_0000, cur_ma} * {24'h00_0000, cur_ma};
            if (n_q[d_s] != 16'hFFFF)
                n_q[d_s] <= n_q[d_s] + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared serial divider and square root
    // steps 0-3 open, 4-7 close: mean, mean square, deviation, force;
    // steps 8-13: speed for close, open, reduced mode (divide, root)

    reg [1:0] pend_q;    // bit 0 full job, bit 1 speed job
    reg [5:0] cnt_q;
    reg [39:0] a_q;      // dividend or radicand, shifted out
    reg [39:0] b_q;      // divisor
    reg [40:0] r_q;      // partial remainder
    reg [39:0] tmp_q;    // intermediate result
    reg [39:0] op_a;
    reg [39:0] op_b;
    reg [31:0] msq;
    wire d_e = step_q[2];
    wire is_sq = step_q[3] ? step_q[0] : (step_q[1:0] == 2'd2);
    wire [21:0] sq_rr = {r_q[19:0], a_q[39:38]};
    wire [21:0] sq_tr = {q_q[19:0], 2'b01};
    wire [40:0] dv_t = {r_q[39:0], a_q[39]};
    wire [39:0] res = (!is_sq && b_q == 40'h0) ? 40'h0 : q_q;

    // operand selection for the step about to be loaded
    always @* begin
        op_a = 40'h00_0000_0000;
        op_b = 40'h00_0000_0001;
        msq = mean_q[d_e] * mean_q[d_e];
        if (!step_q[3]) begin
            case (step_q[1:0])
                2'd0: begin
                    op_a = sum_q[d_e];
                    op_b = {24'h00_0000, n_q[d_e]};
                end
                2'd1: begin
                    op_a = sq_q[d_e];
                    op_b = {24'h00_0000, n_q[d_e]};
                end
                2'd2: begin
                    // variance; rounding may leave it slightly negative
                    if (tmp_q > {8'h00, msq})
                        op_a = tmp_q - {8'h00, msq};
                end
                default: begin
                    op_a = ({24'h00_0000, mean_q[d_e]} + {24'h00_0000, std_q[d_e]})
                           * {24'h00_0000, cfg_q[15]};
                    op_b = `MILLI_DIV;
                end
            endcase
        end else if (!step_q[0]) begin
            op_a = {24'h00_0000, cfg_q[e_idx]} * {16'h0000, `TWO_E6};
            op_b = {24'h00_0000, learned_mass};
        end else begin
            op_a = tmp_q;
        end
    end

    // engine sequencer
    always @(posedge core_clk) begin
        if (sys_rst) begin
            eng_q <= E_IDLE;
            pend_q <= 2'b00;
            step_q <= 4'd0;
            cnt_q <= 6'd0;
            a_q <= 40'h0;
            b_q <= 40'h0;
            q_q <= 40'h0;
            r_q <= 41'h0;
            tmp_q <= 40'h0;
            for (j = 0; j < 2; j = j + 1) begin
                mean_q[j] <= 16'h0000;
                std_q[j] <= 16'h0000;
                fric_q[j] <= 16'h0000;
            end
        end else begin
            // a new event is never lost to the clear
            pend_q <= pend_q | {spd_ev, learn_done};
            case (eng_q)
                E_IDLE: begin
                    if (pend_q[0]) begin
                        step_q <= 4'd0;
                        pend_q <= {1'b0, learn_done};
                        eng_q <= E_LOAD;
                    end else if (pend_q[1]) begin
                        step_q <= 4'd8;
                        pend_q <= {spd_ev, learn_done};
                        eng_q <= E_LOAD;
                    end
                end
                E_LOAD: begin
                    a_q <= op_a;
                    b_q <= op_b;
                    q_q <= 40'h0;
                    r_q <= 41'h0;
                    cnt_q <= is_sq ? 6'd19 : 6'd39;
                    eng_q <= E_RUN;
                end
                E_RUN: begin
                    if (is_sq) begin
                        // one root bit per cycle, floor result
                        a_q <= {a_q[37:0], 2'b00};
                        if (sq_rr >= sq_tr) begin
                            r_q <= {19'h0, sq_rr - sq_tr};
                            q_q <= {q_q[38:0], 1'b1};
                        end else begin
                            r_q <= {19'h0, sq_rr};
                            q_q <= {q_q[38:0], 1'b0};
                        end
                    end else begin
                        a_q <= {a_q[38:0], 1'b0};
                        if (dv_t >= {1'b0, b_q}) begin
                            r_q <= dv_t - {1'b0, b_q};
                            q_q <= {q_q[38:0], 1'b1};
                        end else begin
                            r_q <= dv_t;
                            q_q <= {q_q[38:0], 1'b0};
                        end
                    end
                    if (cnt_q == 6'd0)
                        eng_q <= E_STORE;
                    else
                        cnt_q <= cnt_q - 6'd1;
                end
                default: begin
                    if (!step_q[3]) begin
                        case (step_q[1:0])
                            2'd0: mean_q[d_e] <= sat16(res);
                            2'd1: tmp_q <= res;
                            2'd2: std_q[d_e] <= sat16(res);
                            default: fric_q[d_e] <= sat16(res);
                        endcase
                    end else if (!step_q[0]) begin
                        tmp_q <= res;
                    end
                    step_q <= step_q + 4'd1;
                    eng_q <= (step_q == 4'd13) ? E_IDLE : E_LOAD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // effective force limits: configured force plus friction, clamped

    // sum in 17 bits so a carry cannot wrap below the ceiling
    function [15:0] fsum(input [15:0] f, input [15:0] fr);
        reg [16:0] s;
        begin
            s = {1'b0, f} + {1'b0, fr};
            fsum = (s > {1'b0, `FORCE_MAX_REV}) ? `FORCE_MAX_REV : s[15:0];
        end
    endfunction

    // extra force a follows the opening friction, b the closing one
    always @(posedge core_clk) begin
        if (sys_rst) begin
            eff_open_force <= `FORCE_DEF;
            eff_close_force <= `FORCE_DEF;
            eff_extra_a <= `FORCE_DEF;
            eff_extra_b <= `FORCE_DEF;
        end else begin
            eff_open_force <= fsum(cfg_q[1], fric_q[0]);
            eff_close_force <= fsum(cfg_q[2], fric_q[1]);
            eff_extra_a <= fsum(cfg_q[3], fric_q[0]);
            eff_extra_b <= fsum(cfg_q[4], fric_q[1]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // oscillation protection at the end stops

    reg dir_q;              // 0 open end, 1 closed end
    reg [31:0] tmr_q;       // press-on and lockout timer
    wire at_end = dir_q ? at_close_end : at_open_end;
    wire cmd = dir_q ? cmd_close : cmd_open;

    // state machine; a dropped drive order always ends protection
    always @(posedge core_clk) begin
        if (sys_rst) begin
            os_q <= OS_IDLE;
            reps_q <= 3'd0;
            tmr_q <= 32'h0000_0000;
            dir_q <= 1'b0;
        end else begin
            case (os_q)
                OS_IDLE: begin
                    reps_q <= 3'd0;
                    tmr_q <= 32'h0000_0000;
                    if (cmd_open & at_open_end) begin
                        dir_q <= 1'b0;
                        os_q <= OS_HOLD;
                    end else if (cmd_close & at_close_end) begin
                        dir_q <= 1'b1;
                        os_q <= OS_PRESS;
                    end
                end
                OS_HOLD: begin
                    if (!cmd)
                        os_q <= OS_IDLE;
                    else if (!at_end)
                        os_q <= OS_RET;
                end
                OS_RET: begin
                    if (!cmd) begin
                        os_q <= OS_IDLE;
                    end else if (at_end) begin
                        reps_q <= reps_q + 3'd1;
                        tmr_q <= 32'h0000_0000;
                        if (reps_q == `REPS_MAX - 3'd1)
                            os_q <= OS_LOCK;
                        else
                            os_q <= dir_q ? OS_PRESS : OS_HOLD;
                    end
                end
                OS_PRESS: begin
                    if (!cmd)
                        os_q <= OS_IDLE;
                    else if (!at_end)
                        os_q <= OS_RET;
                    else if (tmr_q == PRESS_CYC - 1)
                        os_q <= OS_HOLD;
                    else
                        tmr_q <= tmr_q + 32'h0000_0001;
                end
                OS_LOCK: begin
                    // push-outs are ignored until the timer runs out
                    if (!cmd) begin
                        os_q <= OS_IDLE;
                    end else if (tmr_q == HOLDOFF_CYC - 1) begin
                        reps_q <= 3'd0;
                        os_q <= OS_HOLD;
                    end else begin
                        tmr_q <= tmr_q + 32'h0000_0001;
                    end
                end
                default: os_q <= OS_IDLE;
            endcase
        end
    end

    // drive outputs follow the state; end stop torques skip friction
    always @(posedge core_clk) begin
        if (sys_rst) begin
            drive_ret <= 2'b00;
            return_force <= 16'h0000;
            torque_cmd <= 16'h0000;
            osc_locked <= 1'b0;
        end else begin
            drive_ret <= (os_q == OS_RET) ? {dir_q, ~dir_q} : 2'b00;
            return_force <= (os_q != OS_RET) ? 16'h0000 :
                            dir_q ? eff_close_force : eff_open_force;
            osc_locked <= (os_q == OS_LOCK);
            case (os_q)
                OS_HOLD, OS_LOCK:
                    torque_cmd <= dir_q ? cfg_q[7] : cfg_q[5];
                OS_PRESS: torque_cmd <= cfg_q[6];
                default: torque_cmd <= 16'h0000;
            endcase
        end
    end

endmodule
`default_nettype wire

// File: include/door_fric_defs.vh
// constants for the door drive friction and energy limit supervisor
// design-side definitions only
`ifndef DOOR_FRIC_DEFS_VH
`define DOOR_FRIC_DEFS_VH

// read-only register byte offsets; config slot n sits at 4n
`define OFS_FRIC_OPEN 8'h40
`define OFS_FRIC_CLOSE 8'h44
`define OFS_FRIC_FORCE 8'h48
`define OFS_STATUS 8'h4C

// control register fields
`define CTRL_REV_BIT 0

// reset values
`define FORCE_DEF 16'h004B
`define ENERGY_DEF 16'h0004
`define SPEED_DEF 16'h00C8
`define CUTTER_DEF 16'h0064
`define MOTOR_K_DEF 16'h0064

// limits of the force and energy parameters
`define FORCE_MAX_REV 16'h0096
`define FORCE_MAX_NOREV 16'h004B
`define ENERGY_MAX_REV 16'h000A
`define ENERGY_MAX_NOREV 16'h0004

// travel figures in mm
`define RANGE1_MM 16'h00FA
`define STEP_MM 16'h0014

// oscillation protection
`define REPS_MAX 3'h5
`define PRESS_MS 2000
`define HOLDOFF_MS 30000
`define CLK_KHZ 10000

// arithmetic scale factors
`define MILLI_DIV 40'h00_0000_03E8
`define TWO_E6 24'h1E_8480

`endif

// File: testbench/door_fric_checker_assertions.sv
// supervisor checker: bus answer, return drive, lockout
// bound onto the supervisor top; sees only its ports
`timescale 1ns/1ns
`default_nettype none
module door_fric_checker #(
    parameter HOLDOFF_CYC = 50
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [15:0] eff_open_force,
    input wire logic [15:0] eff_close_force,
    input wire logic [15:0] eff_extra_a,
    input wire logic [15:0] eff_extra_b,
    input wire logic [1:0] drive_ret,
    input wire logic [15:0] return_force,
    input wire logic osc_locked
);
    // hold-off plus output lag
    localparam int LOCK_MAX = HOLDOFF_CYC + 3;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_bus_answer: assert property (s_req |=> s_ans)
        else $error("late or long bus answer");
    chk_ret_code: assert property (drive_ret != 2'b11)
        else $error("return drive both ways");
    chk_idle_force: assert property (drive_ret == 2'b00 |-> return_force == 16'h0000)
        else $error("stray return force");
    chk_open_ret: assert property (drive_ret == 2'b01 |-> return_force == eff_open_force)
        else $error("open return force wrong");
    chk_close_ret: assert property (drive_ret == 2'b10 |-> return_force == eff_close_force)
        else $error("close return force wrong");
    chk_force_clamp: assert property (eff_open_force <= 16'h0096 && eff_close_force <= 16'h0096
        && eff_extra_a <= 16'h0096 && eff_extra_b <= 16'h0096)
        else $error("force sum above ceiling");
    chk_lock_quiet: assert property (osc_locked && $past(osc_locked) |-> drive_ret == 2'b00)
        else $error("push-out answered during lockout");
    chk_lock_hold: assert property ($rose(osc_locked) |-> osc_locked [*8])
        else $error("lockout ended early");
    chk_lock_ends: assert property ($rose(osc_locked) |-> ##[1:LOCK_MAX] $fell(osc_locked))
        else $error("lockout did not end");
endmodule
bind door_drive_friction_energy_limit door_fric_checker #(.HOLDOFF_CYC(HOLDOFF_CYC)) u_chk (
    .core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .eff_open_force, .eff_close_force, .eff_extra_a, .eff_extra_b, .drive_ret,
    .return_force, .osc_locked);
`default_nettype wire

// File: testbench/door_motor_model.sv
// motor stand-in: 1 mm a clock, steady current
// assumes one sweep direction at a time
`timescale 1ns/1ns
`default_nettype none
module door_motor_model #(
    parameter logic [15:0] AMPS = 16'h03E8
) (
    input wire logic core_clk,
    input wire logic run_open,
    input wire logic run_close,
    output var logic [15:0] pos_mm,
    output wire logic [15:0] cur_ma,
    output wire logic move_open,
    output wire logic move_close,
    output wire logic speed_trig
);
    initial pos_mm = 16'h0000;
    // encoder; stops at zero so closing never wraps
    always @(posedge core_clk) begin
        if (run_open)
            pos_mm <= pos_mm + 16'h0001;
        else if (run_close && pos_mm != 16'h0000)
            pos_mm <= pos_mm - 16'h0001;
    end
    assign move_open = run_open;
    assign move_close = run_close;
    // steady speed: trigger holds all sweep
    assign speed_trig = run_open | run_close;
    assign cur_ma = speed_trig ? AMPS : 16'h0000;
endmodule
`default_nettype wire

// File: testbench/tb_door_drive_friction_energy_limit.sv
// supervisor bench: registers, learn run, speeds, oscillation
// assumes checker bind and motor model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_door_drive_friction_energy_limit;
    logic core_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, we = 1'b0, ack, learn_run = 1'b0;
    logic learn_done = 1'b0, sec_open = 1'b0, run_o = 1'b0, run_c = 1'b0, cmd_o = 1'b0;
    logic cmd_c = 1'b0, end_o = 1'b0, end_c = 1'b0, locked, mv_o, mv_c, trig;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, rdat, r;
    logic [15:0] mass = 16'h0000, pos, cur, eff_o, eff_c, retf, torque;
    logic [1:0] dret;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    always #50 core_clk = ~core_clk;
    door_motor_model u_motor (.core_clk, .run_open(run_o), .run_close(run_c),
        .pos_mm(pos), .cur_ma(cur), .move_open(mv_o), .move_close(mv_c), .speed_trig(trig));
    door_drive_friction_energy_limit #(.PRESS_CYC(20), .HOLDOFF_CYC(50)) DUT (
        .core_clk, .sys_rst, .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'h3), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_ack_o(ack), .learn_run, .learn_done, .move_open(mv_o),
        .move_close(mv_c), .second_open_move(sec_open), .speed_trig(trig), .weight_done(sec_open),
        .eow_pos(16'h0104), .pos_mm(pos), .cur_ma(cur), .learned_mass(mass),
        .cmd_open(cmd_o), .cmd_close(cmd_c), .at_open_end(end_o), .at_close_end(end_c),
        .eff_open_force(eff_o), .eff_close_force(eff_c), .eff_extra_a(), .eff_extra_b(),
        .drive_ret(dret), .return_force(retf), .torque_cmd(torque), .osc_locked(locked));
    ////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // classic cycle: hold to ack, then idle one clock
    task bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        {adr, dat, we, cyc} <= {a, d, w, 1'b1};
        do @(posedge core_clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 32'h0000_0000, 1'b0);
        chk(r, exp);
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // let the engine start, then poll busy; hang guard bounds it
    task wait_idle;
        tick(2);
        do bus(8'h4C, 32'h0000_0000, 1'b0); while (r[0] !== 1'b0);
    endtask
    initial begin
        tick(12);
        sys_rst <= 1'b0;
        tick(1);
        rd(8'h04, 32'h0000_004B);
        rd(8'h20, 32'h0000_0004);
        rd(8'h80, 32'h0000_0000);
        bus(8'h0C, 32'h0000_00C8, 1'b1);
        rd(8'h0C, 32'h0000_004B);
        bus(8'h24, 32'h0000_0014, 1'b1);
        wait_idle;
        rd(8'h24, 32'h0000_0004);
        rd(8'h2C, 32'h0000_00C8);
        bus(8'h04, 32'h0000_001E, 1'b1);
        bus(8'h14, 32'h0000_0011, 1'b1);
        bus(8'h18, 32'h0000_0022, 1'b1);
        bus(8'h1C, 32'h0000_0033, 1'b1);
        // learn run: second opening, then closing
        learn_run <= 1'b1;
        sec_open <= 1'b1;
        run_o <= 1'b1;
        tick(300);
        {sec_open, run_o, run_c} <= 3'b001;
        tick(300);
        {run_c, learn_done, mass} <= {2'b01, 16'h0032};
        tick(1);
        {learn_done, learn_run} <= 2'b00;
        wait_idle;
        rd(8'h40, 32'h0000_03E8);
        rd(8'h44, 32'h0000_03E8);
        rd(8'h48, 32'h0064_0064);
        bus(8'h4C, 32'h0000_0000, 1'b0);
        chk({24'h0, r[15:8]}, 32'h0000_000D);
        chk({16'h0, eff_o}, 32'h0000_0082);
        chk({16'h0, eff_c}, 32'h0000_0096);
        rd(8'h30, 32'h0000_0190);
        rd(8'h2C, 32'h0000_0190);
        rd(8'h34, 32'h0000_0190);
        bus(8'h00, 32'h0000_0001, 1'b1);
        bus(8'h24, 32'h0000_000A, 1'b1);
        wait_idle;
        rd(8'h2C, 32'h0000_0278);
        bus(8'h20, 32'h0000_0000, 1'b1);
        wait_idle;
        bus(8'h30, 32'h0000_0123, 1'b1);
        wait_idle;
        rd(8'h30, 32'h0000_0123);
        // five open push-outs, sixth ignored
        {cmd_o, end_o} <= 2'b11;
        tick(3);
        chk({16'h0, torque}, 32'h0000_0011);
        repeat (5) begin
            end_o <= 1'b0;
            tick(3);
            chk({30'h0, dret}, 32'h0000_0001);
            chk({16'h0, retf}, 32'h0000_0082);
            end_o <= 1'b1;
            tick(3);
        end
        chk({31'h0, locked}, 32'h0000_0001);
        end_o <= 1'b0;
        tick(3);
        chk({30'h0, dret}, 32'h0000_0000);
        end_o <= 1'b1;
        tick(60);
        chk({31'h0, locked}, 32'h0000_0000);
        {cmd_o, end_o} <= 2'b00;
        tick(2);
        // close: press-on, continuous, push-out
        {cmd_c, end_c} <= 2'b11;
        tick(3);
        chk({16'h0, torque}, 32'h0000_0022);
        tick(25);
        chk({16'h0, torque}, 32'h0000_0033);
        end_c <= 1'b0;
        tick(3);
        chk({30'h0, dret}, 32'h0000_0002);
        chk({16'h0, retf}, 32'h0000_0096);
        tally_and_finish;
    end
endmodule
`default_nettype wire
